// ===== tb/msr_master.sv
// behavioural modbus master on the far side of the serial link
`timescale 1ns/1ps
module msr_master #(
  parameter int BIT_CYCLES = 8
) (
  input wire logic clk_sys_i,
  input wire logic line_i,
  output logic tx_o
);
  logic [7:0] rsp[$];
  initial tx_o = 1'b1;
  // reflected crc-16; a frame with its own crc appended leaves zero
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
      end
    end
    return c;
  endfunction
  // send one request, then collect the reply until the line stays idle
  task automatic xfer(input logic [7:0] ad, fn, input logic [15:0] a, v);
    logic [7:0] f[$];
    logic [15:0] c;
    logic [9:0] bits;
    logic [7:0] b;
    int n;
    f = '{ad, fn, a[15:8], a[7:0], v[15:8], v[7:0]};
    c = crc16(f);
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    rsp.delete();
    @(posedge clk_sys_i);
    #1;
    foreach (f[i]) begin
      bits = {1'b1, f[i], 1'b0};
      for (int j = 0; j < 10; j++) begin
        tx_o = bits[j];
        repeat (BIT_CYCLES) @(posedge clk_sys_i);
        #1;
      end
    end
    forever begin
      n = 0;
      // look just after each edge so the slave's freshly launched bit is settled
      while (line_i === 1'b1 && n < 16 * BIT_CYCLES) begin
        @(posedge clk_sys_i);
        #1;
        n++;
      end
      if (n >= 16 * BIT_CYCLES) break;
      repeat (BIT_CYCLES / 2) @(posedge clk_sys_i);
      for (int j = 0; j < 8; j++) begin
        repeat (BIT_CYCLES) @(posedge clk_sys_i);
        #1;
        b[j] = line_i;
      end
      repeat (BIT_CYCLES) @(posedge clk_sys_i);
      rsp.push_back(b);
    end
  endtask
endmodule

// ===== tb/msr_slave_bench.sv
// self-checking bench for the modbus slave register map
`timescale 1ns/1ps
module msr_slave_bench;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic host_rs232_i = 1'b0;
  msr_pkg::msr_meas_wr_s meas_wr_i = '0;
  logic rx_w;
  logic tx_o;
  logic tx_oe_o;
  logic rs232_mode_o;
  logic line_w;
  msr_pkg::msr_cfg_s cfg_o;
  int error_cnt = 0;
  int n_compared = 0;
  int rate[5] = '{9600, 19200, 38400, 57600, 115200};
  logic [7:0] ch[12] = '{8'h30, 8'h39, 8'h41, 8'h5a, 8'h61, 8'h7a,
                         8'h2f, 8'h3a, 8'h40, 8'h5b, 8'h60, 8'h7b};
  logic [15:0] rg[3] = '{16'h00cc, 16'h00cd, 16'h00ce};
  logic [15:0] mx[3] = '{16'd60, 16'd1440, 16'd60};
  always #2 clk_sys_i = ~clk_sys_i;
  // a released rs485 pair is held high by its bias resistors
  assign line_w = tx_oe_o ? tx_o : 1'b1;
  msr_slave #(.BIT_CYCLES(8), .GAP_CYCLES(28)) DUT (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .rx_i(rx_w), .host_rs232_i(host_rs232_i), .meas_wr_i(meas_wr_i),
    .tx_o(tx_o), .tx_oe_o(tx_oe_o), .rs232_mode_o(rs232_mode_o), .cfg_o(cfg_o));
  msr_master #(.BIT_CYCLES(8)) m (.clk_sys_i(clk_sys_i), .line_i(line_w), .tx_o(rx_w));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one request; len 0 means no reply, a nonzero exc an exception reply
  task automatic xt(input logic [7:0] ad, fn, input logic [15:0] a, v,
                    input logic [7:0] exc, input int len);
    m.xfer(ad, fn, a, v);
    chk("reply length", len, m.rsp.size());
    if (len > 0) begin
      chk("reply crc", 0, m.crc16(m.rsp));
      chk("reply head", {ad, exc != 0 ? fn | 8'h80 : fn}, {m.rsp[0], m.rsp[1]});
      if (exc != 0) chk("exception code", exc, m.rsp[2]);
    end
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // cut a hang short
  initial begin
    repeat (95000) @(posedge clk_sys_i);
    error_cnt++;
    $display("mismatch watchdog expected end seen hang");
    end_sim();
  end
  initial begin
    repeat (12) @(posedge clk_sys_i);
    #1 rst_n_i = 1'b1;
    chk("bus_addr", 1, cfg_o.bus_addr);
    chk("dn rate", 19200, cfg_o.dn_baud_rate);
    chk("freeze", 15, cfg_o.wipe_freeze);
    $display("test reset done");
    @(posedge clk_sys_i);
    #1 meas_wr_i = '{1'b1, 5'd0, 32'h41200000};
    @(posedge clk_sys_i);
    #1 meas_wr_i = '{1'b1, 5'd17, 32'hbf800000};
    @(posedge clk_sys_i);
    #1 meas_wr_i.valid = 1'b0;
    xt(0, 3, 16'h0000, 2, 0, 9);
    chk("param1", 32'h41200000, {m.rsp[3], m.rsp[4], m.rsp[5], m.rsp[6]});
    xt(0, 3, 16'h0022, 2, 0, 9);
    chk("param18", 32'hbf800000, {m.rsp[3], m.rsp[4], m.rsp[5], m.rsp[6]});
    xt(0, 3, 16'h0023, 2, 2, 5);
    chk("driver off", 0, tx_oe_o);
    xt(0, 3, 16'h00c8, 1, 0, 7);
    chk("upstream baud", 16'h4b00, {m.rsp[3], m.rsp[4]});
    xt(0, 6, 16'h00c8, 16'h2580, 2, 5);
    xt(0, 8'h04, 16'h0000, 1, 1, 5);
    xt(0, 3, 16'h0000, 0, 3, 5);
    xt(0, 3, 16'h0000, 126, 3, 5);
    xt(0, 3, 16'h00c7, 2, 2, 5);
    xt(0, 6, 16'h00cf, 1, 2, 5);
    $display("test measurements done");
    xt(0, 6, 16'h00c9, 5, 0, 8);
    chk("bus_addr", 5, cfg_o.bus_addr);
    xt(5, 3, 16'h00c9, 1, 0, 7);
    xt(1, 3, 16'h00c9, 1, 0, 0);
    xt(0, 6, 16'h00c9, 251, 3, 5);
    xt(0, 6, 16'h00c9, 0, 3, 5);
    chk("bus_addr kept", 5, cfg_o.bus_addr);
    xt(0, 6, 16'h00c9, 250, 0, 8);
    chk("bus_addr", 250, cfg_o.bus_addr);
    $display("test address done");
    for (int i = 0; i < 5; i++) begin
      xt(0, 6, 16'h00ca, i, 0, 8);
      chk("dn rate", rate[i], cfg_o.dn_baud_rate);
    end
    xt(0, 6, 16'h00ca, 5, 3, 5);
    chk("dn index kept", 4, cfg_o.dn_baud_idx);
    for (int i = 0; i < 12; i++) begin
      xt(0, 6, 16'h00cb, {8'h00, ch[i]}, i < 6 ? 8'h00 : 8'h03, i < 6 ? 8 : 5);
    end
    chk("sdi addr", 8'h7a, cfg_o.sdi_addr);
    for (int i = 0; i < 3; i++) begin
      xt(0, 6, rg[i], mx[i], 0, 8);
      xt(0, 6, rg[i], mx[i] + 16'd1, 3, 5);
    end
    chk("limits", {6'd60, 11'd1440, 6'd60}, {cfg_o.pwr_delay, cfg_o.wipe_interval,
        cfg_o.wipe_freeze});
    xt(0, 6, 16'h00cd, 0, 0, 8);
    chk("wipe enable", 0, cfg_o.wipe_enable);
    $display("test settings done");
    host_rs232_i = 1'b1;
    repeat (4) @(posedge clk_sys_i);
    #1 chk("rs232 mode", 2'b11, {rs232_mode_o, tx_oe_o});
    xt(0, 3, 16'h00c9, 1, 0, 7);
    chk("addr word", 16'h00fa, {m.rsp[3], m.rsp[4]});
    host_rs232_i = 1'b0;
    repeat (4) @(posedge clk_sys_i);
    #1 chk("rs485 mode", 2'b00, {rs232_mode_o, tx_oe_o});
    $display("test line mode done");
    end_sim();
  end
endmodule
bind msr_slave msr_slave_props #(.BIT_CYCLES(BIT_CYCLES)) u_props (.clk_sys_i(clk_sys_i),
  .rst_n_i(rst_n_i), .tx_o(tx_o), .tx_oe_o(tx_oe_o), .rs232_mode_o(rs232_mode_o),
  .cfg_o(cfg_o));

// ===== tb/msr_slave_props.sv
// port assertions for the modbus slave register map
`timescale 1ns/1ps
module msr_slave_props #(
  parameter int BIT_CYCLES = 8
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic tx_o,
  input wire logic tx_oe_o,
  input wire logic rs232_mode_o,
  input wire msr_pkg::msr_cfg_s cfg_o
);
  int low_run;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // length of the current low stretch on the transmit line
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_run <= 0;
    end else begin
      low_run <= tx_o ? 0 : low_run + 1;
    end
  end
  // a low stretch is whole bits and never swallows the stop bit
  property p_char_frame;
    $rose(tx_o) |-> (low_run % BIT_CYCLES == 0) && (low_run <= 9 * BIT_CYCLES);
  endproperty
  a_char_frame: assert property (p_char_frame) else $error("tx low not whole bits");
  property p_idle_high;
    !tx_oe_o |-> tx_o;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("tx low while released");
  property p_full_duplex;
    rs232_mode_o |-> tx_oe_o;
  endproperty
  a_full_duplex: assert property (p_full_duplex) else $error("driver off in rs232");
  property p_oe_start;
    $rose(tx_oe_o) && !rs232_mode_o |-> !tx_o;
  endproperty
  a_oe_start: assert property (p_oe_start) else $error("driver on without start bit");
  property p_oe_end;
    $fell(tx_oe_o) |-> tx_o && $past(tx_o);
  endproperty
  a_oe_end: assert property (p_oe_end) else $error("driver off before stop bit");
  property p_addr;
    cfg_o.bus_addr >= 8'h01 && cfg_o.bus_addr <= 8'hfa;
  endproperty
  a_addr: assert property (p_addr) else $error("bus address out of range");
  property p_rate;
    cfg_o.dn_baud_idx <= 3'h4 && cfg_o.dn_baud_rate == (cfg_o.dn_baud_idx == 3'h0 ? 17'd9600 :
      cfg_o.dn_baud_idx == 3'h1 ? 17'd19200 : cfg_o.dn_baud_idx == 3'h2 ? 17'd38400 :
      cfg_o.dn_baud_idx == 3'h3 ? 17'd57600 : 17'd115200);
  endproperty
  a_rate: assert property (p_rate) else $error("downstream rate wrong");
  property p_limits;
    cfg_o.wipe_freeze <= 6'h3c && cfg_o.wipe_interval <= 11'h5a0 && cfg_o.pwr_delay <= 6'h3c;
  endproperty
  a_limits: assert property (p_limits) else $error("setting out of range");
  property p_sdi;
    (cfg_o.sdi_addr inside {[8'h30:8'h39], [8'h41:8'h5a], [8'h61:8'h7a]});
  endproperty
  a_sdi: assert property (p_sdi) else $error("secondary address not a character");
  property p_wipe;
    cfg_o.wipe_enable == (cfg_o.wipe_interval != 11'h000);
  endproperty
  a_wipe: assert property (p_wipe) else $error("wipe enable wrong");
endmodule

// ===== verilog/msr_pkg.sv
// constants, types and shared functions of the modbus slave register map
package msr_pkg;
  // system clock and the fixed upstream line rate
  localparam int CLK_HZ = 250_000_000;
  localparam int UP_BAUD = 19_200;
  localparam int BIT_CYC = CLK_HZ / UP_BAUD;
  // frame gap of 3.5 characters, 10 bits each, in tenths of a bit
  localparam int GAP_BITS_X10 = 350;
  localparam int GAP_CYC = (BIT_CYC * GAP_BITS_X10) / 10;
  localparam int CHAR_BITS = 10;

  // holding register offsets (protocol offset n is holding register 40001 + n)
  localparam logic [15:0] MEAS_FIRST = 16'h0000;
  localparam logic [15:0] MEAS_LAST = 16'h0023;
  localparam logic [15:0] REG_UP_BAUD = 16'h00c8;
  localparam logic [15:0] REG_BUS_ADDR = 16'h00c9;
  localparam logic [15:0] REG_DN_BAUD = 16'h00ca;
  localparam logic [15:0] REG_SDI_ADDR = 16'h00cb;
  localparam logic [15:0] REG_PWR_DELAY = 16'h00cc;
  localparam logic [15:0] REG_WIPE_INT = 16'h00cd;
  localparam logic [15:0] REG_WIPE_FRZ = 16'h00ce;
  localparam int N_PARAM = 18;

  // values after reset
  localparam logic [7:0] BUS_ADDR_RST = 8'h01;
  localparam logic [2:0] DN_BAUD_RST = 3'h1;
  localparam logic [7:0] SDI_ADDR_RST = 8'h30;
  localparam logic [5:0] PWR_DELAY_RST = 6'h00;
  localparam logic [10:0] WIPE_INT_RST = 11'h000;
  localparam logic [5:0] WIPE_FRZ_RST = 6'h0f;

  // legal ranges of the settings
  localparam logic [15:0] BUS_ADDR_MIN = 16'h0001;
  localparam logic [15:0] BUS_ADDR_MAX = 16'h00fa;
  localparam logic [15:0] DN_BAUD_MAX = 16'h0004;
  localparam logic [15:0] PWR_DELAY_MAX = 16'h003c;
  localparam logic [15:0] WIPE_INT_MAX = 16'h05a0;
  localparam logic [15:0] WIPE_FRZ_MAX = 16'h003c;
  localparam logic [15:0] UP_BAUD_WORD = 16'h4b00;

  // protocol codes
  localparam logic [7:0] ANY_ADDR = 8'h00;
  localparam logic [7:0] FN_READ_HOLD = 8'h03;
  localparam logic [7:0] FN_WRITE_ONE = 8'h06;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;
  localparam logic [15:0] MAX_QTY = 16'h007d;
  localparam logic [3:0] REQ_LEN = 4'h8;
  localparam logic [7:0] EXC_LEN = 8'h05;
  localparam logic [7:0] ECHO_LEN = 8'h08;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;

  typedef enum logic [1:0] {
    MSR_IDLE = 2'b00,
    MSR_RECV = 2'b01,
    MSR_EXEC = 2'b11,
    MSR_SEND = 2'b10
  } msr_fsm_e;

  typedef struct packed {
    logic [7:0] bus_addr;
    logic [2:0] dn_baud_idx;
    logic [16:0] dn_baud_rate;
    logic [7:0] sdi_addr;
    logic [5:0] pwr_delay;
    logic [10:0] wipe_interval;
    logic [5:0] wipe_freeze;
    logic wipe_enable;
  } msr_cfg_s;

  typedef struct packed {
    logic valid;
    logic [4:0] index;
    logic [31:0] value;
  } msr_meas_wr_s;

  // one byte of the reflected crc-16 used on the link
  function automatic logic [15:0] msr_crc_byte(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  // downstream rate in bits per second for an index
  function automatic logic [16:0] msr_dn_rate(input logic [2:0] idx);
    logic [16:0] r;
    unique case (idx)
      3'h0: r = 17'h02580;
      3'h1: r = 17'h04b00;
      3'h2: r = 17'h09600;
      3'h3: r = 17'h0e100;
      3'h4: r = 17'h1c200;
      default: r = 17'h04b00;
    endcase
    return r;
  endfunction
endpackage

// ===== verilog/msr_slave.sv
// modbus rtu slave with measurement and settings holding registers
//
// Operation
// - characters are 8 data, no parity, 1 stop
// - link runs at 19200 bits per second
// - full-duplex or half-duplex shared line pair
// - host indication selects rs232, else rs485
// - measurements from register 40001, two words each
// - each measurement is an ieee-754 single word
// - bus address register 1..250, resets to 1
// - requests to address 0 also answered
// - downstream index 0..4 maps 9600..115200
// - settings at holding registers 40201 to 40207
// - upstream baud register reads fixed 19200
// - secondary address is digit or letter
// - freeze 0..60 s, interval 0..1440 min
// - zero wipe interval disables auto wiping
`timescale 1ns/1ps
module msr_slave #(
  parameter int BIT_CYCLES = msr_pkg::BIT_CYC,
  parameter int GAP_CYCLES = msr_pkg::GAP_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic rx_i,
  input wire logic host_rs232_i,
  input wire msr_pkg::msr_meas_wr_s meas_wr_i,
  output logic tx_o,
  output logic tx_oe_o,
  output logic rs232_mode_o,
  output msr_pkg::msr_cfg_s cfg_o
);
  localparam int TW = $clog2(BIT_CYCLES + 1);
  localparam int GW = $clog2(GAP_CYCLES + 1);
  localparam logic [TW-1:0] BIT_LAST = TW'(BIT_CYCLES - 1);
  localparam logic [TW-1:0] BIT_HALF = TW'(BIT_CYCLES / 2);
  localparam logic [GW-1:0] GAP_DONE = GW'(GAP_CYCLES);
  localparam logic [3:0] STOP_BIT = 4'(msr_pkg::CHAR_BITS - 1);

  // the timers cannot serve a bit shorter than four clocks or a gap under one bit
  if (BIT_CYCLES < 4 || GAP_CYCLES < BIT_CYCLES) begin : g_bad_timing
    $error("msr_slave: BIT_CYCLES or GAP_CYCLES out of range");
  end

  typedef struct packed {
    msr_pkg::msr_fsm_e fsm;
    logic rs232;
    logic rx_busy;
    logic [TW-1:0] rx_tmr;
    logic [3:0] rx_bit;
    logic [7:0] rx_sh;
    logic [GW-1:0] gap;
    logic [3:0] cnt;
    logic bad;
    logic [7:0][7:0] req;
    logic [15:0] crc_rx;
    logic [7:0] ntx;
    logic [7:0] tx_idx;
    logic [3:0] tx_bit;
    logic [TW-1:0] tx_tmr;
    logic [9:0] tx_sh;
    logic [15:0] crc_tx;
    logic [7:0] exc;
    logic tx_oe;
    logic [msr_pkg::N_PARAM-1:0][31:0] meas;
    msr_pkg::msr_cfg_s cfg;
  } msr_state_s;

  msr_state_s st;
  msr_state_s next_st;
  logic rx_done;
  logic [7:0] rx_byte;
  logic [15:0] start;
  logic [15:0] qty;
  logic [16:0] last;
  logic [7:0] ld_idx;
  logic [7:0] ld_byte;
  logic ld_data;

  // word seen by the master at a protocol offset
  function automatic logic [15:0] reg_word(input logic [15:0] a);
    logic [15:0] w;
    w = 16'h0000;
    if (a <= msr_pkg::MEAS_LAST) begin
      w = a[0] ? st.meas[a[5:1]][15:0] : st.meas[a[5:1]][31:16];
    end else begin
      unique case (a)
        msr_pkg::REG_UP_BAUD: w = msr_pkg::UP_BAUD_WORD;
        msr_pkg::REG_BUS_ADDR: w = {8'h00, st.cfg.bus_addr};
        msr_pkg::REG_DN_BAUD: w = {13'h0000, st.cfg.dn_baud_idx};
        msr_pkg::REG_SDI_ADDR: w = {8'h00, st.cfg.sdi_addr};
        msr_pkg::REG_PWR_DELAY: w = {10'h000, st.cfg.pwr_delay};
        msr_pkg::REG_WIPE_INT: w = {5'h00, st.cfg.wipe_interval};
        msr_pkg::REG_WIPE_FRZ: w = {10'h000, st.cfg.wipe_freeze};
        default: w = 16'h0000;
      endcase
    end
    return w;
  endfunction

  // value check for a single register write
  function automatic logic wr_ok(input logic [15:0] a, input logic [15:0] v);
    logic ok;
    ok = 1'b0;
    unique case (a)
      msr_pkg::REG_BUS_ADDR:
        ok = v >= msr_pkg::BUS_ADDR_MIN && v <= msr_pkg::BUS_ADDR_MAX;
      msr_pkg::REG_DN_BAUD: ok = v <= msr_pkg::DN_BAUD_MAX;
      msr_pkg::REG_SDI_ADDR:
        ok = (v >= 16'h0030 && v <= 16'h0039) || (v >= 16'h0041 && v <= 16'h005a)
          || (v >= 16'h0061 && v <= 16'h007a);
      msr_pkg::REG_PWR_DELAY: ok = v <= msr_pkg::PWR_DELAY_MAX;
      msr_pkg::REG_WIPE_INT: ok = v <= msr_pkg::WIPE_INT_MAX;
      msr_pkg::REG_WIPE_FRZ: ok = v <= msr_pkg::WIPE_FRZ_MAX;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // content byte of the reply at a given position, crc excluded
  function automatic logic [7:0] resp_byte(input logic [7:0] idx);
    logic [7:0] b;
    logic [7:0] d;
    logic [15:0] w;
    b = 8'h00;
    d = idx - 8'h03;
    w = reg_word(st.req[2] * 16'h0100 + {8'h00, st.req[3]} + {9'h000, d[7:1]});
    if (idx == 8'h00) begin
      b = st.req[0];
    end else if (idx == 8'h01) begin
      b = (st.exc != msr_pkg::EXC_NONE) ? (st.req[1] | msr_pkg::EXC_FLAG) : st.req[1];
    end else if (st.exc != msr_pkg::EXC_NONE) begin
      b = st.exc;
    end else if (st.req[1] == msr_pkg::FN_WRITE_ONE) begin
      b = st.req[idx[2:0]];
    end else if (idx == 8'h02) begin
      b = {st.req[5][6:0], 1'b0};
    end else begin
      b = d[0] ? w[7:0] : w[15:8];
    end
    return b;
  endfunction

  // request fields and the next byte to put on the line
  always_comb begin
    start = {st.req[2], st.req[3]};
    qty = {st.req[4], st.req[5]};
    last = {1'b0, start} + {1'b0, qty} - 17'h00001;
    ld_idx = (st.fsm == msr_pkg::MSR_EXEC) ? 8'h00 : st.tx_idx + 8'h01;
    ld_data = ld_idx < st.ntx - 8'h02;
    if (ld_data) begin
      ld_byte = resp_byte(ld_idx);
    end else if (ld_idx == st.ntx - 8'h02) begin
      ld_byte = st.crc_tx[7:0];
    end else begin
      ld_byte = st.crc_tx[15:8];
    end
  end

  // all next-state logic
  always_comb begin
    next_st = st;
    rx_done = 1'b0;
    rx_byte = st.rx_sh;

    // receiver samples mid-bit; a character whose stop bit is low is dropped
    if (!st.rx_busy) begin
      if (!rx_i) begin
        next_st.rx_busy = 1'b1;
        next_st.rx_tmr = BIT_HALF;
        next_st.rx_bit = 4'h0;
      end
    end else if (st.rx_tmr != '0) begin
      next_st.rx_tmr = st.rx_tmr - TW'(1);
    end else begin
      next_st.rx_tmr = BIT_LAST;
      next_st.rx_bit = st.rx_bit + 4'h1;
      if (st.rx_bit == 4'h0 && rx_i) begin
        next_st.rx_busy = 1'b0; // glitch, not a start bit
      end else if (st.rx_bit == STOP_BIT) begin
        next_st.rx_busy = 1'b0;
        rx_done = rx_i;
        if (!rx_i && st.fsm == msr_pkg::MSR_RECV) begin
          next_st.bad = 1'b1;
        end
      end else if (st.rx_bit != 4'h0) begin
        next_st.rx_sh = {rx_i, st.rx_sh[7:1]};
      end
    end

    // silence timer marks the end of a frame
    if (st.rx_busy || !rx_i) begin
      next_st.gap = '0;
    end else if (st.gap != GAP_DONE) begin
      next_st.gap = st.gap + GW'(1);
    end

    // measurement values arrive already in single-precision format
    if (meas_wr_i.valid && meas_wr_i.index < 5'(msr_pkg::N_PARAM)) begin
      next_st.meas[meas_wr_i.index] = meas_wr_i.value;
    end

    unique case (st.fsm)
      msr_pkg::MSR_IDLE: begin
        next_st.rs232 = host_rs232_i;
        next_st.cnt = 4'h0;
        next_st.bad = 1'b0;
        next_st.crc_rx = msr_pkg::CRC_INIT;
        next_st.crc_tx = msr_pkg::CRC_INIT;
        if (rx_done) begin
          next_st.req[0] = rx_byte;
          next_st.cnt = 4'h1;
          next_st.crc_rx = msr_pkg::msr_crc_byte(msr_pkg::CRC_INIT, rx_byte);
          next_st.fsm = msr_pkg::MSR_RECV;
        end
      end
      msr_pkg::MSR_RECV: begin
        // only eight-byte requests are served; longer ones are dropped silently
        if (rx_done) begin
          if (st.cnt < msr_pkg::REQ_LEN) begin
            next_st.req[st.cnt[2:0]] = rx_byte;
            next_st.cnt = st.cnt + 4'h1;
            next_st.crc_rx = msr_pkg::msr_crc_byte(st.crc_rx, rx_byte);
          end else begin
            next_st.bad = 1'b1;
          end
        end else if (st.gap == GAP_DONE) begin
          if (!st.bad && st.cnt == msr_pkg::REQ_LEN && st.crc_rx == 16'h0000
              && (st.req[0] == st.cfg.bus_addr || st.req[0] == msr_pkg::ANY_ADDR)) begin
            next_st.fsm = msr_pkg::MSR_EXEC;
          end else begin
            next_st.fsm = msr_pkg::MSR_IDLE;
          end
        end
      end
      msr_pkg::MSR_EXEC: begin
        next_st.exc = msr_pkg::EXC_NONE;
        next_st.ntx = msr_pkg::EXC_LEN;
        if (st.req[1] == msr_pkg::FN_READ_HOLD) begin
          if (qty == 16'h0000 || qty > msr_pkg::MAX_QTY) begin
            next_st.exc = msr_pkg::EXC_VALUE;
          end else if (!(last <= {1'b0, msr_pkg::MEAS_LAST}
                       || (start >= msr_pkg::REG_UP_BAUD
                           && last <= {1'b0, msr_pkg::REG_WIPE_FRZ}))) begin
            next_st.exc = msr_pkg::EXC_ADDR;
          end else begin
            next_st.ntx = msr_pkg::EXC_LEN + {qty[6:0], 1'b0};
          end
        end else if (st.req[1] == msr_pkg::FN_WRITE_ONE) begin
          if (start < msr_pkg::REG_BUS_ADDR || start > msr_pkg::REG_WIPE_FRZ) begin
            next_st.exc = msr_pkg::EXC_ADDR;
          end else if (!wr_ok(start, qty)) begin
            next_st.exc = msr_pkg::EXC_VALUE;
          end else begin
            next_st.ntx = msr_pkg::ECHO_LEN;
            unique case (start)
              msr_pkg::REG_BUS_ADDR: next_st.cfg.bus_addr = qty[7:0];
              msr_pkg::REG_DN_BAUD: next_st.cfg.dn_baud_idx = qty[2:0];
              msr_pkg::REG_SDI_ADDR: next_st.cfg.sdi_addr = qty[7:0];
              msr_pkg::REG_PWR_DELAY: next_st.cfg.pwr_delay = qty[5:0];
              msr_pkg::REG_WIPE_INT: next_st.cfg.wipe_interval = qty[10:0];
              default: next_st.cfg.wipe_freeze = qty[5:0];
            endcase
          end
        end else begin
          next_st.exc = msr_pkg::EXC_FUNC;
        end
        // first byte is the echoed address, known before the reply length
        next_st.tx_idx = 8'h00;
        next_st.tx_sh = {1'b1, ld_byte, 1'b0};
        next_st.tx_bit = 4'h0;
        next_st.tx_tmr = BIT_LAST;
        next_st.crc_tx = msr_pkg::msr_crc_byte(st.crc_tx, ld_byte);
        next_st.fsm = msr_pkg::MSR_SEND;
      end
      msr_pkg::MSR_SEND: begin
        // own echo on the shared pair is ignored while sending
        if (st.tx_tmr != '0) begin
          next_st.tx_tmr = st.tx_tmr - TW'(1);
        end else if (st.tx_bit != STOP_BIT) begin
          next_st.tx_tmr = BIT_LAST;
          next_st.tx_bit = st.tx_bit + 4'h1;
          next_st.tx_sh = {1'b1, st.tx_sh[9:1]};
        end else if (ld_idx == st.ntx) begin
          next_st.fsm = msr_pkg::MSR_IDLE;
        end else begin
          next_st.tx_idx = ld_idx;
          next_st.tx_sh = {1'b1, ld_byte, 1'b0};
          next_st.tx_bit = 4'h0;
          next_st.tx_tmr = BIT_LAST;
          if (ld_data) begin
            next_st.crc_tx = msr_pkg::msr_crc_byte(st.crc_tx, ld_byte);
          end
        end
      end
    endcase

    // rs232 keeps its own transmit line driven; rs485 drives only while replying
    next_st.tx_oe = next_st.fsm == msr_pkg::MSR_SEND || next_st.rs232;
    next_st.cfg.dn_baud_rate = msr_pkg::msr_dn_rate(next_st.cfg.dn_baud_idx);
    next_st.cfg.wipe_enable = next_st.cfg.wipe_interval != 11'h000;
  end

  // state register with documented defaults
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
      st.fsm <= msr_pkg::MSR_IDLE;
      st.tx_sh <= 10'h3ff;
      st.crc_rx <= msr_pkg::CRC_INIT;
      st.crc_tx <= msr_pkg::CRC_INIT;
      st.cfg.bus_addr <= msr_pkg::BUS_ADDR_RST;
      st.cfg.dn_baud_idx <= msr_pkg::DN_BAUD_RST;
      st.cfg.dn_baud_rate <= 17'h04b00;
      st.cfg.sdi_addr <= msr_pkg::SDI_ADDR_RST;
      st.cfg.pwr_delay <= msr_pkg::PWR_DELAY_RST;
      st.cfg.wipe_interval <= msr_pkg::WIPE_INT_RST;
      st.cfg.wipe_freeze <= msr_pkg::WIPE_FRZ_RST;
    end else begin
      st <= next_st;
    end
  end

  assign tx_o = st.tx_sh[0];
  assign tx_oe_o = st.tx_oe;
  assign rs232_mode_o = st.rs232;
  assign cfg_o = st.cfg;
endmodule
